// >>> shared/ecpf_pkg.sv
// package: register map, field layout, timing and carrier types of the ecp port controller
//
// Contract
// - reverse pio sets service bit at rx level
// - read-only full and empty fifo flags
// - modes 010/011 run automatic line handshake
// - mode change out of 010/011 drops auto feed immediately
// - address port bytes sent tagged as command
// - reverse ecp handshakes bytes into the fifo
// - dma requested through one request line
// - dma always targets the fifo at 0x400
// - terminal count stops dma, sets service bit
// - request never held over 32 dma cycles
// - pio service interrupt at tx/rx level
// - fault falling edge or re-enable interrupts
// - ack interrupt when enabled, edge style
// - test mode keeps fifo reachable for probing
// - standard fifo mode paced by busy and fixed setup, strobe and hold timing
// - ext control top bits select the mode
// - direction low drives data bus outward
`default_nettype none
package ecpf_pkg;
	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [11:0] A_DATA = 12'h000;
	localparam logic [11:0] A_DSR = 12'h004;
	localparam logic [11:0] A_DCR = 12'h008;
	localparam logic [11:0] A_ACMD = 12'h00C;
	localparam logic [11:0] A_FIFO = 12'h400;
	localparam logic [11:0] A_CFGB = 12'h404;
	localparam logic [11:0] A_ECR = 12'h408;
	localparam logic [11:0] A_LEVELS = 12'h40C;

	// ------------------------------------------------------------
	// modes held in ext_control_register[7:5]
	// ------------------------------------------------------------
	localparam int ECR_MODE_LSB = 5;
	localparam int ECR_ERR_DIS = 4;
	localparam int ECR_DMA_EN = 3;
	localparam int ECR_SVC = 2;
	localparam int ECR_FULL = 1;
	localparam int ECR_EMPTY = 0;
	localparam logic [2:0] MODE_SPP = 3'h0;
	localparam logic [2:0] MODE_PS2 = 3'h1;
	localparam logic [2:0] MODE_FIFO = 3'h2;
	localparam logic [2:0] MODE_ECP = 3'h3;
	localparam logic [2:0] MODE_TEST = 3'h6;
	localparam logic [2:0] MODE_CFG = 3'h7;
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic ERR_DIS_RST = 1'b1;
	localparam logic DMA_EN_RST = 1'b0;
	localparam logic SVC_RST = 1'b1;

	// ------------------------------------------------------------
	// device control bits, status and config values
	// ------------------------------------------------------------
	localparam int DCR_DIR = 5;
	localparam int DCR_ACK_IE = 4;
	localparam int DCR_SEL = 3;
	localparam int DCR_INIT = 2;
	localparam int DCR_AFD = 1;
	localparam int DCR_STB = 0;
	localparam logic [5:0] DCR_RST = 6'h00;
	localparam logic [1:0] DCR_TOP_ONES = 2'h3;
	localparam logic [2:0] DSR_LOW_ONES = 3'h7;
	localparam logic [7:0] CFGA_VALUE = 8'h10;
	localparam logic [7:0] CFGB_VALUE = 8'h00;

	// ------------------------------------------------------------
	// fifo and dma defaults
	// ------------------------------------------------------------
	localparam int FIFO_DEPTH_DEF = 16;
	localparam logic [7:0] TX_LEVEL_DEF = 8'h08;
	localparam logic [7:0] RX_LEVEL_DEF = 8'h08;
	localparam logic [5:0] DMA_BURST_MAX = 6'h20;

	// ------------------------------------------------------------
	// timing: 10 mhz clock, 2 us per standard byte (500 kbyte/s)
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 10;
	localparam int SETUP_NS = 500;
	localparam int STROBE_NS = 1000;
	localparam int HOLD_NS = 500;

	function automatic int ns_to_cyc_min(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc_min

	localparam logic [7:0] SETUP_CNT = 8'(ns_to_cyc_min(SETUP_NS) - 1);
	localparam logic [7:0] STROBE_CNT = 8'(ns_to_cyc_min(STROBE_NS) - 1);
	localparam logic [7:0] HOLD_CNT = 8'(ns_to_cyc_min(HOLD_NS) - 1);

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic cmd;
		logic [7:0] data;
	} ecpf_entry_t;

	typedef struct packed {
		logic write;
		logic mapped;
		logic [11:0] addr;
	} ecpf_aphase_t;
endpackage : ecpf_pkg
`default_nettype wire

// >>> logic/ecpf_fifo.sv
// module: byte fifo with tag bit shared by host, dma and port handshake
`timescale 1ns/1ns
`default_nettype none
module ecpf_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16,
	parameter int CNT_W = 5
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] head,
	output logic [CNT_W-1:0] count,
	output logic full,
	output logic empty
);
	import ecpf_pkg::*;
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic do_push, do_pop;

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		return (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
	endfunction : ptr_inc

	assign full = (cnt_reg == CNT_W'(DEPTH));
	assign empty = (cnt_reg == '0);
	assign count = cnt_reg;
	assign head = mem[rd_reg];

	// a push into a full fifo only lands when a pop frees a slot the same cycle
	always_comb begin
		do_pop = pop && !empty;
		do_push = push && (!full || do_pop);
		wr_next = do_push ? ptr_inc(wr_reg) : wr_reg;
		rd_next = do_pop ? ptr_inc(rd_reg) : rd_reg;
		cnt_next = cnt_reg;
		if (do_push && !do_pop) begin
			cnt_next = CNT_W'(cnt_reg + 1'b1);
		end else if (do_pop && !do_push) begin
			cnt_next = CNT_W'(cnt_reg - 1'b1);
		end
		if (clear) begin
			wr_next = '0;
			rd_next = '0;
			cnt_next = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_reg] <= push_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end
endmodule : ecpf_fifo
`default_nettype wire

// >>> logic/ecpf_port_ctrl.sv
// module: ecp parallel port fifo, mode, dma and event control behind an ahb-lite slave
`timescale 1ns/1ns
`default_nettype none
module ecpf_port_ctrl #(
	parameter int FIFO_DEPTH = ecpf_pkg::FIFO_DEPTH_DEF,
	parameter logic [7:0] TX_LEVEL = ecpf_pkg::TX_LEVEL_DEF,
	parameter logic [7:0] RX_LEVEL = ecpf_pkg::RX_LEVEL_DEF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [7:0] pd_in,
	output logic [7:0] pd_out,
	output logic pd_oe,
	output logic data_strobe_out_n,
	output logic auto_feed_out_n,
	output logic init_out_n,
	output logic select_in_out_n,
	input wire logic busy_in,
	input wire logic peripheral_ack_in_n,
	input wire logic peripheral_error_in_n,
	input wire logic paper_end_in,
	input wire logic select_in,
	output logic dma_req,
	input wire logic dma_ack,
	input wire logic dma_tc,
	input wire logic [7:0] dma_wdata,
	output logic [7:0] dma_rdata,
	output logic irq
);
	import ecpf_pkg::*;
	localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

	typedef enum logic [2:0] {
		ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_ECP_ACK, ST_ECP_REL, ST_REV_ACK
	} ecpf_state_t;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ecpf_aphase_t ap_reg, ap_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic [7:0] data_reg, data_next, last_rd_reg, last_rd_next;
	logic [5:0] dcr_reg, dcr_next;
	logic [2:0] mode_reg, mode_next;
	logic err_dis_reg, err_dis_next, dma_en_reg, dma_en_next, svc_reg, svc_next;
	logic fault_prev_reg, ack_prev_reg;
	ecpf_state_t state_reg, state_next;
	logic [7:0] tmr_reg, tmr_next;
	ecpf_entry_t xfer_reg, xfer_next;
	logic strobe_n_reg, strobe_n_next, afd_n_reg, afd_n_next;
	logic [7:0] pd_out_reg, pd_out_next, dma_rdata_reg, dma_rdata_next;
	logic pd_oe_reg, pd_oe_next, irq_reg, irq_next, dma_req_reg, dma_req_next;
	logic init_n_reg, sel_n_reg;
	logic [5:0] burst_reg, burst_next;

	logic aphase, dir, dir_next, hw_mode, fifo_mode, fifo_rd_mode, fifo_wr_mode;
	logic dma_go, dma_go_next, err_evt, ack_evt, svc_cond;
	logic fifo_push, fifo_pop, f_full, f_empty, f_clear;
	ecpf_entry_t fifo_push_data, f_head;
	logic [CNT_W-1:0] f_count, f_free;

	function automatic logic is_mapped(input logic [31:0] a);
		return (a[31:12] == '0) && (a[11:0] inside {A_DATA, A_DSR, A_DCR, A_ACMD,
			A_FIFO, A_CFGB, A_ECR, A_LEVELS});
	endfunction : is_mapped

	// effective direction: forced forward in the standard and fifo modes
	function automatic logic dir_of(input logic [2:0] m, input logic [5:0] d);
		return d[DCR_DIR] && (m != MODE_SPP) && (m != MODE_FIFO);
	endfunction : dir_of

	function automatic logic is_fifo_mode(input logic [2:0] m);
		return (m == MODE_FIFO) || (m == MODE_ECP) || (m == MODE_TEST);
	endfunction : is_fifo_mode

	assign aphase = hsel && htrans[1] && hready;
	assign dir = dir_of(mode_reg, dcr_reg);
	assign hw_mode = (mode_reg == MODE_FIFO) || (mode_reg == MODE_ECP);
	assign fifo_mode = is_fifo_mode(mode_reg);
	assign fifo_rd_mode = (mode_reg == MODE_TEST) || (mode_reg == MODE_ECP && dir);
	assign fifo_wr_mode = (mode_reg == MODE_TEST) || (hw_mode && !dir);
	assign dma_go = dma_en_reg && !svc_reg && fifo_mode;
	assign f_clear = (mode_reg == MODE_SPP);
	assign f_free = CNT_W'(FIFO_DEPTH) - f_count;

	// ------------------------------------------------------------
	// fifo
	// ------------------------------------------------------------
	ecpf_fifo #(
		.WIDTH($bits(ecpf_entry_t)),
		.DEPTH(FIFO_DEPTH),
		.CNT_W(CNT_W)
	) u_fifo (
		.clk(hclk),
		.rst_n(hresetn),
		.clear(f_clear),
		.push(fifo_push),
		.push_data(fifo_push_data),
		.pop(fifo_pop),
		.head(f_head),
		.count(f_count),
		.full(f_full),
		.empty(f_empty)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		ap_next = '{write: aphase && hwrite, mapped: is_mapped(haddr), addr: haddr[11:0]};
		hrdata_next = hrdata_reg;
		data_next = data_reg;
		dcr_next = dcr_reg;
		mode_next = mode_reg;
		err_dis_next = err_dis_reg;
		dma_en_next = dma_en_reg;
		svc_next = svc_reg;
		last_rd_next = last_rd_reg;
		dma_rdata_next = dma_rdata_reg;
		fifo_push = 1'b0;
		fifo_push_data = '0;
		fifo_pop = 1'b0;
		err_evt = 1'b0;
		svc_cond = 1'b0;
		state_next = state_reg;
		tmr_next = tmr_reg;
		xfer_next = xfer_reg;
		strobe_n_next = strobe_n_reg;
		afd_n_next = afd_n_reg;

		// read answered from the address phase, so data stands in the data phase
		if (aphase && !hwrite) begin
			hrdata_next = 32'h0000_0000;
			if (is_mapped(haddr)) begin
				case (haddr[11:0])
				A_DATA: hrdata_next[7:0] = (mode_reg == MODE_PS2 && dir) ? pd_in : data_reg;
				A_DSR: hrdata_next[7:0] = {!busy_in, peripheral_ack_in_n, paper_end_in,
					select_in, peripheral_error_in_n, DSR_LOW_ONES};
				A_DCR: hrdata_next[7:0] = {DCR_TOP_ONES, dir, dcr_reg[4:0]};
				A_FIFO: begin
					if (mode_reg == MODE_CFG) begin
						hrdata_next[7:0] = CFGA_VALUE;
					end else if (fifo_rd_mode) begin
						// empty fifo repeats the last byte read
						hrdata_next[7:0] = f_empty ? last_rd_reg : f_head.data;
						fifo_pop = !f_empty;
						if (!f_empty) begin
							last_rd_next = f_head.data;
						end
					end
				end
				A_CFGB: hrdata_next[7:0] = (mode_reg == MODE_CFG) ? CFGB_VALUE : 8'h00;
				A_ECR: hrdata_next[7:0] = {mode_reg, err_dis_reg, dma_en_reg, svc_reg,
					f_full, f_empty};
				A_LEVELS: hrdata_next[23:0] = {8'(FIFO_DEPTH), RX_LEVEL, TX_LEVEL};
				default: hrdata_next = 32'h0000_0000;
				endcase
			end
		end

		// writes take effect at the end of the data phase
		if (ap_reg.write && ap_reg.mapped) begin
			case (ap_reg.addr)
			A_DATA: data_next = hwdata[7:0];
			A_DCR: dcr_next = hwdata[5:0];
			A_ACMD: begin
				if (mode_reg == MODE_ECP && !dir) begin
					fifo_push = 1'b1;
					fifo_push_data = '{cmd: 1'b1, data: hwdata[7:0]};
				end
			end
			A_FIFO: begin
				if (fifo_wr_mode) begin
					fifo_push = 1'b1;
					fifo_push_data = '{cmd: 1'b0, data: hwdata[7:0]};
				end
			end
			A_ECR: begin
				mode_next = hwdata[7:5];
				err_dis_next = hwdata[ECR_ERR_DIS];
				dma_en_next = hwdata[ECR_DMA_EN];
				svc_next = hwdata[ECR_SVC];
				err_evt = err_dis_reg && !hwdata[ECR_ERR_DIS] && !peripheral_error_in_n;
			end
			default: ;
			endcase
		end

		// dma moves bytes only through the fifo; it wins over a host access that cycle
		if (dma_ack && dma_go) begin
			if (dir) begin
				fifo_pop = !f_empty;
				dma_rdata_next = f_head.data;
			end else begin
				fifo_push = 1'b1;
				fifo_push_data = '{cmd: 1'b0, data: dma_wdata};
			end
		end

		// hardware set of the service bit wins over a clearing write
		if (fifo_mode && !svc_reg) begin
			if (dma_en_reg) begin
				svc_cond = dma_ack && dma_tc;
			end else if (dir) begin
				svc_cond = 16'(f_count) >= 16'(RX_LEVEL);
			end else begin
				svc_cond = 16'(f_free) >= 16'(TX_LEVEL);
			end
		end
		if (svc_cond) begin
			svc_next = 1'b1;
		end
		if (fault_prev_reg && !peripheral_error_in_n && !err_dis_reg) begin
			err_evt = 1'b1;
		end

		// automatic handshake; software drives the lines in all other modes
		case (state_reg)
		ST_IDLE: begin
			if (mode_reg == MODE_ECP && dir) begin
				afd_n_next = f_full;
				if (!peripheral_ack_in_n && !afd_n_reg && !f_full) begin
					fifo_push = 1'b1;
					fifo_push_data = '{cmd: 1'b0, data: pd_in};
					afd_n_next = 1'b1;
					state_next = ST_REV_ACK;
				end
			end else if (hw_mode && !dir && !f_empty && !busy_in) begin
				fifo_pop = 1'b1;
				xfer_next = f_head;
				afd_n_next = (mode_reg == MODE_ECP) ? !f_head.cmd : 1'b1;
				tmr_next = SETUP_CNT;
				state_next = ST_SETUP;
			end else if (!hw_mode) begin
				strobe_n_next = !dcr_reg[DCR_STB];
				afd_n_next = !dcr_reg[DCR_AFD];
			end
		end
		ST_SETUP: begin
			tmr_next = tmr_reg - 8'h01;
			if (tmr_reg == 8'h00) begin
				strobe_n_next = 1'b0;
				tmr_next = STROBE_CNT;
				state_next = (mode_reg == MODE_ECP) ? ST_ECP_ACK : ST_STROBE;
			end
		end
		ST_STROBE: begin
			tmr_next = tmr_reg - 8'h01;
			if (tmr_reg == 8'h00) begin
				strobe_n_next = 1'b1;
				tmr_next = HOLD_CNT;
				state_next = ST_HOLD;
			end
		end
		ST_HOLD: begin
			tmr_next = tmr_reg - 8'h01;
			if (tmr_reg == 8'h00) begin
				state_next = ST_IDLE;
			end
		end
		ST_ECP_ACK: begin
			if (busy_in) begin
				strobe_n_next = 1'b1;
				state_next = ST_ECP_REL;
			end
		end
		ST_ECP_REL: begin
			if (!busy_in) begin
				afd_n_next = 1'b1;
				state_next = ST_IDLE;
			end
		end
		ST_REV_ACK: begin
			if (peripheral_ack_in_n) begin
				state_next = ST_IDLE;
			end
		end
		default: state_next = ST_IDLE;
		endcase

		// mode change aborts any transfer; leaving fifo or ecp mode releases both strobes at once
		if (mode_next != mode_reg || !hw_mode) begin
			state_next = ST_IDLE;
			if (hw_mode) begin
				strobe_n_next = 1'b1;
				afd_n_next = 1'b1;
			end
		end

		dir_next = dir_of(mode_next, dcr_next);
		pd_oe_next = !dir_next;
		if (hw_mode && !dir) begin
			pd_out_next = xfer_next.data;
		end else if (mode_reg == MODE_TEST) begin
			pd_out_next = f_head.data;
		end else begin
			pd_out_next = data_next;
		end

		irq_next = (svc_cond && !svc_reg) || err_evt || ack_evt;

		// request dropped for a cycle after 32 back-to-back dma cycles
		burst_next = burst_reg;
		if (!dma_req_reg) begin
			burst_next = 6'h00;
		end else if (dma_ack) begin
			burst_next = burst_reg + 6'h01;
		end
		dma_go_next = dma_en_next && !svc_next && is_fifo_mode(mode_next);
		dma_req_next = dma_go_next && (burst_next < DMA_BURST_MAX) && (dir
			? (f_count > CNT_W'(fifo_pop))
			: (f_free > CNT_W'(fifo_push)));
	end

	// acknowledge interrupt on the rising edge of the ack input
	assign ack_evt = dcr_reg[DCR_ACK_IE] && !ack_prev_reg && peripheral_ack_in_n;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_reg <= '0;
			hrdata_reg <= 32'h0000_0000;
			data_reg <= 8'h00;
			last_rd_reg <= 8'h00;
			dcr_reg <= DCR_RST;
			mode_reg <= MODE_RST;
			err_dis_reg <= ERR_DIS_RST;
			dma_en_reg <= DMA_EN_RST;
			svc_reg <= SVC_RST;
			fault_prev_reg <= 1'b1;
			ack_prev_reg <= 1'b1;
			state_reg <= ST_IDLE;
			tmr_reg <= 8'h00;
			xfer_reg <= '0;
			strobe_n_reg <= 1'b1;
			afd_n_reg <= 1'b1;
			pd_out_reg <= 8'h00;
			pd_oe_reg <= 1'b1;
			dma_rdata_reg <= 8'h00;
			irq_reg <= 1'b0;
			dma_req_reg <= 1'b0;
			burst_reg <= 6'h00;
			init_n_reg <= 1'b0;
			sel_n_reg <= 1'b1;
		end else begin
			ap_reg <= ap_next;
			hrdata_reg <= hrdata_next;
			data_reg <= data_next;
			last_rd_reg <= last_rd_next;
			dcr_reg <= dcr_next;
			mode_reg <= mode_next;
			err_dis_reg <= err_dis_next;
			dma_en_reg <= dma_en_next;
			svc_reg <= svc_next;
			fault_prev_reg <= peripheral_error_in_n;
			ack_prev_reg <= peripheral_ack_in_n;
			state_reg <= state_next;
			tmr_reg <= tmr_next;
			xfer_reg <= xfer_next;
			strobe_n_reg <= strobe_n_next;
			afd_n_reg <= afd_n_next;
			pd_out_reg <= pd_out_next;
			pd_oe_reg <= pd_oe_next;
			dma_rdata_reg <= dma_rdata_next;
			irq_reg <= irq_next;
			dma_req_reg <= dma_req_next;
			burst_reg <= burst_next;
			init_n_reg <= dcr_next[DCR_INIT];
			sel_n_reg <= !dcr_next[DCR_SEL];
		end
	end

	// zero-wait slave, every answer okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign pd_out = pd_out_reg;
	assign pd_oe = pd_oe_reg;
	assign data_strobe_out_n = strobe_n_reg;
	assign auto_feed_out_n = afd_n_reg;
	assign init_out_n = init_n_reg;
	assign select_in_out_n = sel_n_reg;
	assign dma_req = dma_req_reg;
	assign dma_rdata = dma_rdata_reg;
	assign irq = irq_reg;
endmodule : ecpf_port_ctrl
`default_nettype wire

// >>> tb/ecpf_periph_model.sv
// model: parallel peripheral answering forward and reverse port handshakes
`timescale 1ns/1ns
`default_nettype none
module ecpf_periph_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic data_strobe_out_n,
	input wire logic auto_feed_out_n,
	input wire logic [7:0] pd_out,
	input wire logic rev,
	input wire logic hold,
	input wire logic slow,
	output logic busy_in,
	output logic peripheral_ack_in_n,
	output logic [7:0] pd_in,
	output logic [8:0] last,
	output logic [7:0] cnt
);
	logic [3:0] w;
	logic [7:0] nxt;
	logic drv;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_in <= 1'b0;
			peripheral_ack_in_n <= 1'b1;
			pd_in <= 8'h00;
			last <= 9'h000;
			cnt <= 8'h00;
			w <= 4'h0;
			nxt <= 8'hA0;
			drv <= 1'b0;
		end else begin
			w <= data_strobe_out_n ? 4'h0 : w + 4'h1;
			// hold keeps busy up so the fifo can be filled
			if (data_strobe_out_n)
				busy_in <= hold;
			else if (!busy_in && w >= (slow ? 4'h6 : 4'h0)) begin
				busy_in <= 1'b1;
				last <= {!auto_feed_out_n, pd_out};
				cnt <= cnt + 8'h01;
			end
			if (rev && !auto_feed_out_n && peripheral_ack_in_n && !drv) begin
				pd_in <= nxt;
				drv <= 1'b1;
			end else if (drv && peripheral_ack_in_n && !auto_feed_out_n)
				peripheral_ack_in_n <= 1'b0;
			else if (auto_feed_out_n && !peripheral_ack_in_n) begin
				peripheral_ack_in_n <= 1'b1;
				drv <= 1'b0;
				nxt <= nxt + 8'h01;
				// released bus shows the inverse so stale data cannot pass
				pd_in <= ~pd_in;
			end
		end
	end
endmodule : ecpf_periph_model
`default_nettype wire

// >>> tb/ecpf_port_ctrl_sva.sv
// checker: port assertions of the ecp port controller
`timescale 1ns/1ns
`default_nettype none
module ecpf_port_ctrl_sva (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [7:0] pd_out,
	input wire logic data_strobe_out_n,
	input wire logic auto_feed_out_n,
	input wire logic busy_in,
	input wire logic peripheral_ack_in_n,
	input wire logic dma_req,
	input wire logic dma_ack,
	input wire logic dma_tc,
	input wire logic irq
);
	import ecpf_pkg::*;
	logic wr_q;
	logic [2:0] mode_q;
	logic [5:0] burst_q;
	// mode shadow: the checker only sees bus traffic
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			mode_q <= MODE_RST;
			burst_q <= 6'h00;
		end else begin
			wr_q <= hsel && htrans[1] && hready && hwrite && haddr == {20'h0_0000, A_ECR};
			if (wr_q)
				mode_q <= hwdata[7:5];
			burst_q <= dma_req ? burst_q + {5'h00, dma_ack} : 6'h00;
		end
	end
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	ahb_okay_a:
		assert property (hreadyout && !hresp) else $error("slave stalled or erred");
	afd_abort_a:
		assert property (wr_q && mode_q == MODE_ECP && hwdata[7:5] != MODE_ECP |-> ##2 auto_feed_out_n)
		else $error("auto feed held after mode change");
	fifo_strobe_a:
		assert property (mode_q == MODE_FIFO && $fell(data_strobe_out_n)
		|-> ##9 !data_strobe_out_n ##1 data_strobe_out_n) else $error("strobe width wrong");
	data_hold_a:
		assert property ((mode_q == MODE_FIFO || mode_q == MODE_ECP) && !data_strobe_out_n
		|=> $stable(pd_out)) else $error("data moved under strobe");
	ecp_strobe_a:
		assert property (mode_q == MODE_ECP && !data_strobe_out_n && !busy_in
		|=> !data_strobe_out_n) else $error("strobe released before busy");
	rev_afd_a:
		assert property (mode_q == MODE_ECP && !auto_feed_out_n && !peripheral_ack_in_n
		|-> ##[1:2] auto_feed_out_n) else $error("reverse byte not acknowledged");
	tc_stop_a:
		assert property (dma_req && dma_ack && dma_tc |-> ##2 !dma_req) else $error("dma after tc");
	tc_irq_a:
		assert property (dma_req && dma_ack && dma_tc |-> ##[1:3] irq) else $error("no tc irq");
	burst_cap_a:
		assert property (burst_q <= 6'h20) else $error("request held over burst limit");
	cover property (dma_ack && dma_tc);
	cover property (mode_q == MODE_FIFO && $fell(data_strobe_out_n));
	cover property (mode_q == MODE_ECP && !auto_feed_out_n && !peripheral_ack_in_n);
endmodule : ecpf_port_ctrl_sva
bind ecpf_port_ctrl ecpf_port_ctrl_sva i_sva (.*);
`default_nettype wire

// >>> tb/ecpf_port_ctrl_tb.sv
// testbench: register, fifo, dma and event tests of the ecp port controller
`timescale 1ns/1ns
`default_nettype none
module ecpf_port_ctrl_tb;
	import ecpf_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b1;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic peripheral_error_in_n = 1'b1;
	logic paper_end_in = 1'b0;
	logic select_in = 1'b1;
	logic dma_ack = 1'b0;
	logic dma_tc = 1'b0;
	logic [7:0] dma_wdata = 8'h00;
	logic rev = 1'b0;
	logic hold = 1'b0;
	logic slow = 1'b0;
	logic hreadyout, hresp, pd_oe, init_out_n, select_in_out_n, busy_in, peripheral_ack_in_n;
	logic data_strobe_out_n, auto_feed_out_n, dma_req, irq;
	logic [7:0] pd_in, pd_out, dma_rdata, cnt;
	logic [8:0] last;
	logic [31:0] hrdata, r;
	int bad_count = 0;
	int check_count = 0;
	int cyc = 0;
	int irq_cnt = 0;
	int irq_mark = 0;
	ecpf_port_ctrl i_dut (.*, .hready(hreadyout));
	ecpf_periph_model i_per (.*);
	always #50 hclk = ~hclk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// one word transfer; waits on hready in both phases
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, {20'h0_0000, a}, {24'h00_0000, d});
	endtask : wr
	task automatic rd(input logic [11:0] a);
		bus(1'b0, {20'h0_0000, a}, 32'h0000_0000);
	endtask : rd
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		rd(a);
		chk(r, {24'h00_0000, e});
	endtask : rdc
	task automatic poll(input int b);
		for (int k = 0; k < 300; k++) begin
			rd(A_ECR);
			if (r[b] === 1'b1)
				break;
		end
	endtask : poll
	// empty alone is not enough: the last byte is still on the wire
	task automatic drain;
		poll(ECR_EMPTY);
		repeat (30) @(posedge hclk);
	endtask : drain
	// pulses are counted all the time, so one that lands inside a bus or dma task is not lost
	task automatic wirq(input int n, input logic e);
		repeat (n) @(posedge hclk);
		chk(32'(irq_cnt != irq_mark), 32'(e));
		irq_mark = irq_cnt;
	endtask : wirq
	task automatic dma_byte(input logic [7:0] b, input logic tc);
		for (int k = 0; k < 300 && dma_req !== 1'b1; k++)
			@(posedge hclk);
		dma_ack <= 1'b1;
		dma_tc <= tc;
		dma_wdata <= b;
		@(posedge hclk);
		dma_ack <= 1'b0;
		dma_tc <= 1'b0;
		@(posedge hclk);
	endtask : dma_byte
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	always @(posedge hclk) begin
		cyc++;
		if (irq === 1'b1)
			irq_cnt++;
		if (cyc == 20000) begin
			bad_count++;
			print_verdict;
		end
	end
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc(A_ECR, 8'h15);
		rdc(A_DCR, 8'hC0);
		chk({29'h0, pd_oe, init_out_n, select_in_out_n}, 32'h0000_0005);
		bus(1'b0, 32'h0000_1000, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		$display("done reset");
		slow <= 1'b1;
		wr(A_ECR, 8'h74);
		wr(A_ACMD, 8'h5A);
		drain;
		chk(32'(last), 32'h0000_015A);
		wr(A_FIFO, 8'hA5);
		drain;
		chk(32'(last), 32'h0000_00A5);
		$display("done ecp forward");
		slow <= 1'b0;
		hold <= 1'b1;
		wr(A_ECR, 8'h34);
		wr(A_ECR, 8'h54);
		for (int i = 0; i < 17; i++)
			wr(A_FIFO, 8'h10 + 8'(i));
		rdc(A_ECR, 8'h56);
		hold <= 1'b0;
		drain;
		rdc(A_ECR, 8'h55);
		chk(32'(last), 32'h0000_001F);
		chk(32'(cnt), 32'h0000_0012);
		$display("done fifo mode");
		wr(A_ECR, 8'h58);
		for (int i = 0; i < 20; i++) begin
			if (i == 10) begin
				wr(A_ECR, 8'h5C);
				wr(A_ECR, 8'h54);
				chk(32'(dma_req), 32'h0000_0000);
				wr(A_ECR, 8'h5C);
				wr(A_ECR, 8'h58);
			end
			dma_byte(8'h80 + 8'(i), i == 19);
		end
		wirq(4, 1'b1);
		rd(A_ECR);
		chk(r & 32'h0000_00E4, 32'h0000_0044);
		drain;
		$display("done dma");
		wr(A_ECR, 8'h34);
		wr(A_DCR, 8'h20);
		rev <= 1'b1;
		wr(A_ECR, 8'h70);
		wirq(80, 1'b1);
		chk(32'(pd_oe), 32'h0000_0000);
		poll(ECR_FULL);
		for (int i = 0; i < 16; i++)
			rdc(A_FIFO, 8'hA0 + 8'(i));
		rev <= 1'b0;
		repeat (20) rd(A_FIFO);
		chk(32'(auto_feed_out_n), 32'h0000_0000);
		wr(A_ECR, 8'h34);
		@(posedge hclk);
		chk(32'(auto_feed_out_n), 32'h0000_0001);
		$display("done reverse");
		wr(A_ECR, 8'h24);
		peripheral_error_in_n <= 1'b0;
		wirq(5, 1'b1);
		peripheral_error_in_n <= 1'b1;
		wr(A_ECR, 8'h34);
		peripheral_error_in_n <= 1'b0;
		wirq(5, 1'b0);
		wr(A_ECR, 8'h24);
		wirq(5, 1'b1);
		$display("done fault");
		wr(A_ECR, 8'h14);
		wr(A_ECR, 8'hD4);
		wr(A_FIFO, 8'h3C);
		rdc(A_FIFO, 8'h3C);
		rdc(A_FIFO, 8'h3C);
		rd(A_LEVELS);
		chk(r, 32'h0010_0808);
		wr(A_ECR, 8'h34);
		wr(A_ECR, 8'hF4);
		rdc(A_FIFO, 8'h10);
		rdc(A_CFGB, 8'h00);
		$display("done test mode");
		print_verdict;
	end
endmodule : ecpf_port_ctrl_tb
`default_nettype wire
